//--- core/tmc_pkg.sv
// package with constants and types for the dual 8-bit timer / event counter
package tmc_pkg;
   // clock select codes
   localparam logic [2:0] SEL_HF_2048 = 3'h0; // or low clock / 8
   localparam logic [2:0] SEL_HF_128 = 3'h1;
   localparam logic [2:0] SEL_HF_32 = 3'h2;
   localparam logic [2:0] SEL_HF_8 = 3'h3;
   localparam logic [2:0] SEL_LF = 3'h4;
   localparam logic [2:0] SEL_HF_2 = 3'h5;
   localparam logic [2:0] SEL_HF = 3'h6;
   localparam logic [2:0] SEL_PIN = 3'h7;
   // mode codes; upper codes with bit 2 set, with the lower counter in MODE_LOW16, make it the high byte of a 16-bit mode
   localparam logic [2:0] MODE_TMR8 = 3'h0; // 8-bit timer or event counter
   localparam logic [2:0] MODE_PDO8 = 3'h1;
   localparam logic [2:0] MODE_PWM8 = 3'h2;
   localparam logic [2:0] MODE_LOW16 = 3'h3; // lower counter as low byte
   localparam logic [2:0] MODE_TMR16 = 3'h4;
   localparam logic [2:0] MODE_WARM16 = 3'h5;
   localparam logic [2:0] MODE_PWM16 = 3'h6;
   localparam logic [2:0] MODE_PPG16 = 3'h7;
   localparam int CASCADE_BIT = 2;
   // prescaler
   localparam int HF_DIV_W = 11;
   localparam int LF_DIV_W = 3;
   localparam logic [HF_DIV_W-1:0] HF_DIV_RST = 11'h000;
   localparam logic [LF_DIV_W-1:0] LF_DIV_RST = 3'h0;
   localparam logic [7:0] CNT_RST = 8'h00;
   localparam logic [7:0] CNT_ONE = 8'h01;
   localparam logic [7:0] CNT_MAX = 8'hFF;
   // per-counter control set by software
   typedef struct packed {
      logic run;
      logic [2:0] mode;
      logic [2:0] clk_sel;
      logic ff_init; // output flip-flop initial value, unused in these modes
      logic [7:0] period;
   } tmc_ctl_s;
   // prescaled ticks
   typedef struct packed {
      logic hf;
      logic hf_2;
      logic hf_8;
      logic hf_32;
      logic hf_128;
      logic hf_2048;
      logic lf;
      logic lf_8;
   } tmc_tick_s;
endpackage

//--- core/tmc_timer.sv
// dual cascadable 8-bit timer / event counter with source legality checks
// Behaviour
// (R01) timer mode counts selected tick; on period match: pulse irq, clear, continue
// (R02) period register unbuffered, used live; software avoids rewriting while running
// (R03) software keeps output flip-flop init at 0 in these modes
// (R04) event counter mode counts falling edges of own event pin
// (R05) event mode match pulses irq and clears; counting resumes on later edges
// (R06) event pin levels held at least two machine cycles by the source
// (R07) software keeps 8-bit period 1..255, 8-bit duty 2..254
// (R08) software keeps 16-bit period/duty within documented ranges
// (R09) 16-bit pulse mode: duty>=1, duty+1<period<=65535
// (R10) full speed timer/DIVIDER_OUTPUT_MODE/16-bit timer accept only the four prescaled taps
// (R11) full speed PWM accepts all internal sources; 16-bit PWM/PROGRAMMABLE_PULSE_MODE add pin; code gives PROGRAMMABLE_PULSE_MODE only the four taps and pin
// (R12) low speed: timer/DIVIDER_OUTPUT_MODE/PROGRAMMABLE_PULSE_MODE low/8 only, PWM adds low clock, warm-up high
// (R13) 8-bit event uses own pin; 16-bit event uses lower pin only
// (R14) 16-bit modes take their source from lower clock select field
// (R15) lower and upper counters cascade into one 16-bit counter
// (R16) select codes 000..011 taps, 100 low, 101 half high, 110 high, 111 pin
// (R17) software changes mode/select/init only with the start of a run
// (R18) upper byte of 16-bit mode is clocked by lower overflow
// (R19) event pin synchronised; falling edge from successive samples
// (R20) irq is a one-cycle pulse in the clearing cycle
`timescale 1ns/1ps
`default_nettype none
module tmc_timer (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic HF_TICK,
   input wire logic LF_TICK,
   input wire logic LOW_SPEED,
   input wire logic PRESCALE_TAP_SELECT,
   input wire tmc_pkg::tmc_ctl_s LOWER_CTL,
   input wire tmc_pkg::tmc_ctl_s UPPER_CTL,
   input wire logic LOWER_EVENT_PIN,
   input wire logic UPPER_EVENT_PIN,
   output logic [7:0] LOWER_COUNT,
   output logic [7:0] UPPER_COUNT,
   output logic LOWER_IRQ,
   output logic UPPER_IRQ,
   output logic LOWER_SRC_ERR,
   output logic UPPER_SRC_ERR
);
   // source legality per mode and speed
   function automatic logic src_legal(input logic [2:0] mode, input logic [2:0] sel, input logic low);
      logic tap;
      tap = (sel <= tmc_pkg::SEL_HF_8);
      unique case (mode)
         tmc_pkg::MODE_TMR8, tmc_pkg::MODE_TMR16: // see (R10) (R12) (R13)
            src_legal = (sel == tmc_pkg::SEL_PIN) || (low ? sel == tmc_pkg::SEL_HF_2048 : tap);
         tmc_pkg::MODE_PDO8: // see (R10) (R12)
            src_legal = low ? sel == tmc_pkg::SEL_HF_2048 : tap;
         tmc_pkg::MODE_PWM8: // see (R11) (R12)
            src_legal = low ? (sel == tmc_pkg::SEL_HF_2048 || sel == tmc_pkg::SEL_LF) : sel != tmc_pkg::SEL_PIN;
         tmc_pkg::MODE_PWM16: // see (R11) (R12)
            src_legal = low ? (sel == tmc_pkg::SEL_HF_2048 || sel == tmc_pkg::SEL_LF || sel == tmc_pkg::SEL_PIN)
                            : 1'b1;
         tmc_pkg::MODE_WARM16: // see (R11) (R12)
            src_legal = low ? sel == tmc_pkg::SEL_HF : sel == tmc_pkg::SEL_LF;
         tmc_pkg::MODE_PPG16: // see (R11) (R12)
            src_legal = (sel == tmc_pkg::SEL_PIN) || (low ? sel == tmc_pkg::SEL_HF_2048 : tap);
         default:
            src_legal = 1'b0; // lower-byte code only valid under a cascade
      endcase
   endfunction

   // tick chosen by a select code
   function automatic logic src_tick(input logic [2:0] sel, input tmc_pkg::tmc_tick_s t, input logic pin_fall,
                                     input logic dv7, input logic low);
      unique case (sel) // see (R16)
         tmc_pkg::SEL_HF_2048: src_tick = (dv7 || low) ? t.lf_8 : t.hf_2048;
         tmc_pkg::SEL_HF_128: src_tick = t.hf_128;
         tmc_pkg::SEL_HF_32: src_tick = t.hf_32;
         tmc_pkg::SEL_HF_8: src_tick = t.hf_8;
         tmc_pkg::SEL_LF: src_tick = t.lf;
         tmc_pkg::SEL_HF_2: src_tick = t.hf_2;
         tmc_pkg::SEL_HF: src_tick = t.hf;
         tmc_pkg::SEL_PIN: src_tick = pin_fall;
      endcase
   endfunction

   logic [tmc_pkg::HF_DIV_W-1:0] hf_div_q;
   logic [tmc_pkg::LF_DIV_W-1:0] lf_div_q;
   tmc_pkg::tmc_tick_s tick;

   // free-running prescaler; taps pulse when the low divider bits wrap
   assign tick.hf = HF_TICK;
   assign tick.hf_2 = HF_TICK & hf_div_q[0];
   assign tick.hf_8 = HF_TICK & (&hf_div_q[2:0]);
   assign tick.hf_32 = HF_TICK & (&hf_div_q[4:0]);
   assign tick.hf_128 = HF_TICK & (&hf_div_q[6:0]);
   assign tick.hf_2048 = HF_TICK & (&hf_div_q);
   assign tick.lf = LF_TICK;
   assign tick.lf_8 = LF_TICK & (&lf_div_q);

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         hf_div_q <= tmc_pkg::HF_DIV_RST;
         lf_div_q <= tmc_pkg::LF_DIV_RST;
      end else begin
         hf_div_q <= hf_div_q + {{(tmc_pkg::HF_DIV_W-1){1'b0}}, HF_TICK};
         lf_div_q <= lf_div_q + {{(tmc_pkg::LF_DIV_W-1){1'b0}}, LF_TICK};
      end
   end

   // event pins: two-stage synchroniser then one history stage
   logic lo_meta_q, up_meta_q, lo_sync_q, up_sync_q, lo_prev_q, up_prev_q;
   logic lo_fall, up_fall;
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         lo_meta_q <= 1'b1; // idle-high history, so no false edge follows reset
         up_meta_q <= 1'b1;
         lo_sync_q <= 1'b1;
         up_sync_q <= 1'b1;
         lo_prev_q <= 1'b1;
         up_prev_q <= 1'b1;
      end else begin
         lo_meta_q <= LOWER_EVENT_PIN; // see (R19)
         up_meta_q <= UPPER_EVENT_PIN;
         lo_sync_q <= lo_meta_q;
         up_sync_q <= up_meta_q;
         lo_prev_q <= lo_sync_q;
         up_prev_q <= up_sync_q;
      end
   end
   // the source guarantees two-cycle levels, so one sample per level is never missed
   assign lo_fall = lo_prev_q & ~lo_sync_q; // see (R19) (R06)
   assign up_fall = up_prev_q & ~up_sync_q;

   // mode decode; upper mode bit 2 and the lower mode code steer a cascade
   logic cascade, lo_ok, up_ok, lo_tick, up_tick;
   logic lo_cnt8, up_cnt8;
   assign cascade = UPPER_CTL.mode[tmc_pkg::CASCADE_BIT] && LOWER_CTL.mode == tmc_pkg::MODE_LOW16; // see (R15)
   assign lo_ok = cascade ? src_legal(UPPER_CTL.mode, LOWER_CTL.clk_sel, LOW_SPEED) // see (R14)
                          : src_legal(LOWER_CTL.mode, LOWER_CTL.clk_sel, LOW_SPEED);
   assign up_ok = cascade ? lo_ok : src_legal(UPPER_CTL.mode, UPPER_CTL.clk_sel, LOW_SPEED);
   // 16-bit event mode sees only the lower pin; 8-bit uses each counter's own pin
   assign lo_tick = src_tick(LOWER_CTL.clk_sel, tick, lo_fall, PRESCALE_TAP_SELECT, LOW_SPEED); // see (R04) (R13)
   assign up_tick = src_tick(UPPER_CTL.clk_sel, tick, up_fall, PRESCALE_TAP_SELECT, LOW_SPEED);
   assign lo_cnt8 = !cascade && LOWER_CTL.run && lo_ok && LOWER_CTL.mode == tmc_pkg::MODE_TMR8 && lo_tick;
   assign up_cnt8 = !cascade && UPPER_CTL.run && up_ok && UPPER_CTL.mode == tmc_pkg::MODE_TMR8 && up_tick;

   // next-count arithmetic; the period is compared live, with no shadow copy
   logic [7:0] lo_inc, up_inc;
   logic lo_hit8, up_hit8, cas_step, lo_carry, hit16;
   assign lo_inc = LOWER_COUNT + tmc_pkg::CNT_ONE;
   assign up_inc = UPPER_COUNT + tmc_pkg::CNT_ONE;
   assign lo_hit8 = lo_inc == LOWER_CTL.period; // see (R01) (R02)
   assign up_hit8 = up_inc == UPPER_CTL.period;
   assign cas_step = cascade && UPPER_CTL.run && lo_ok && UPPER_CTL.mode == tmc_pkg::MODE_TMR16 && lo_tick;
   assign lo_carry = LOWER_COUNT == tmc_pkg::CNT_MAX; // overflow clocks the high byte, see (R18)
   assign hit16 = {(lo_carry ? up_inc : UPPER_COUNT), lo_inc} == {UPPER_CTL.period, LOWER_CTL.period};

   // counters; a stopped counter sits at zero so every run starts from a clean count
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         LOWER_COUNT <= tmc_pkg::CNT_RST;
         UPPER_COUNT <= tmc_pkg::CNT_RST;
         LOWER_IRQ <= 1'b0;
         UPPER_IRQ <= 1'b0;
      end else begin
         LOWER_IRQ <= lo_cnt8 && lo_hit8; // see (R20)
         UPPER_IRQ <= (up_cnt8 && up_hit8) || (cas_step && hit16);
         if (cascade) begin
            if (!UPPER_CTL.run) begin
               LOWER_COUNT <= tmc_pkg::CNT_RST;
               UPPER_COUNT <= tmc_pkg::CNT_RST;
            end else if (cas_step) begin
               LOWER_COUNT <= hit16 ? tmc_pkg::CNT_RST : lo_inc; // see (R15) (R01) (R05)
               UPPER_COUNT <= hit16 ? tmc_pkg::CNT_RST : (lo_carry ? up_inc : UPPER_COUNT); // see (R18)
            end
         end else begin
            if (!LOWER_CTL.run)
               LOWER_COUNT <= tmc_pkg::CNT_RST;
            else if (lo_cnt8)
               LOWER_COUNT <= lo_hit8 ? tmc_pkg::CNT_RST : lo_inc; // see (R01) (R04) (R05)
            if (!UPPER_CTL.run)
               UPPER_COUNT <= tmc_pkg::CNT_RST;
            else if (up_cnt8)
               UPPER_COUNT <= up_hit8 ? tmc_pkg::CNT_RST : up_inc;
         end
      end
   end

   // illegal source flags, shown while the counter is told to run
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         LOWER_SRC_ERR <= 1'b0;
         UPPER_SRC_ERR <= 1'b0;
      end else begin
         LOWER_SRC_ERR <= (cascade ? UPPER_CTL.run : LOWER_CTL.run) && !lo_ok; // see (R10) (R12)
         UPPER_SRC_ERR <= UPPER_CTL.run && !up_ok;
      end
   end

   // checks
   AST_LO_MATCH_CLEAR: assert property (@(posedge CLK_SYS) disable iff (RST) // see (R01)
      lo_cnt8 && lo_hit8 |=> LOWER_IRQ && LOWER_COUNT == 8'h00) else $error("lower match did not clear");
   AST_LO_INC: assert property (@(posedge CLK_SYS) disable iff (RST) // see (R04)
      lo_cnt8 && !lo_hit8 |=> LOWER_COUNT == $past(LOWER_COUNT) + 8'h01) else $error("lower count missed step");
   AST_UP_HOLD: assert property (@(posedge CLK_SYS) disable iff (RST) // see (R05)
      UPPER_CTL.run && !cascade && !up_cnt8 |=> $stable(UPPER_COUNT)) else $error("upper count moved idle");
   AST_IRQ_PULSE: assert property (@(posedge CLK_SYS) disable iff (RST) // see (R20)
      LOWER_IRQ |-> LOWER_COUNT == 8'h00 ##1 !LOWER_IRQ || $past(lo_hit8, 1)) else $error("irq not tied to clear");
   AST_FALL_EDGE: assert property (@(posedge CLK_SYS) disable iff (RST) // see (R19)
      lo_fall |-> ##1 !lo_fall) else $error("edge detect held");
   AST_SRC_ERR: assert property (@(posedge CLK_SYS) disable iff (RST) // see (R10)
      !cascade && LOWER_CTL.run && LOWER_CTL.mode == tmc_pkg::MODE_TMR8 && !LOW_SPEED
      && LOWER_CTL.clk_sel[2] && LOWER_CTL.clk_sel != tmc_pkg::SEL_PIN
      |=> LOWER_SRC_ERR) else $error("undivided source accepted in timer mode");
   AST_CASCADE_CARRY: assert property (@(posedge CLK_SYS) disable iff (RST) // see (R18)
      cas_step && !hit16 && LOWER_COUNT == 8'hFF |=> LOWER_COUNT == 8'h00 && UPPER_COUNT == $past(UPPER_COUNT) + 8'h01)
      else $error("carry not passed to high byte");
   AST_CASCADE_HIT: assert property (@(posedge CLK_SYS) disable iff (RST) // see (R15)
      cas_step && hit16 |=> UPPER_IRQ && UPPER_COUNT == 8'h00 && LOWER_COUNT == 8'h00) else $error("16-bit match lost");
   AST_TAP_RATE: assert property (@(posedge CLK_SYS) disable iff (RST) // see (R16)
      tick.hf_8 |=> !tick.hf_8 [*7]) else $error("tap fires too often");
endmodule
`default_nettype wire

//--- core/tmc_unused_placeholder_none.sv
// intentionally empty design unit list: all logic lives in tmc_timer
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- tb/tmc_event_src.sv
// external pulse source model for one event input pin
`timescale 1ns/1ps
`default_nettype none
module tmc_event_src (
   input wire logic CLK_SYS,
   output logic PIN
);
   initial PIN = 1'b1;
   // n falling edges; both levels held at least two cycles, idle high
   task automatic pulses(input int n, input int hold);
      int h;
      h = (hold < 2) ? 2 : hold;
      repeat (n) begin
         @(posedge CLK_SYS);
         PIN <= 1'b0;
         repeat (h) @(posedge CLK_SYS);
         PIN <= 1'b1;
         repeat (h - 1) @(posedge CLK_SYS);
      end
   endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// self-checking testbench for the dual timer / event counter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 1'b0, rst = 1'b1, hf_tick = 1'b1, lf_tick = 1'b1, low_speed = 1'b0, tap_sel = 1'b0;
   tmc_pkg::tmc_ctl_s lo_ctl = '0, up_ctl = '0;
   wire logic lo_pin, up_pin;
   logic [7:0] lower_count, upper_count;
   logic lower_irq, upper_irq, lower_err, upper_err;
   int err_total = 0, compares = 0;
   always #10 clk = ~clk;
   tmc_event_src src_lo (.CLK_SYS(clk), .PIN(lo_pin));
   tmc_event_src src_up (.CLK_SYS(clk), .PIN(up_pin));
   tmc_timer DUT (.CLK_SYS(clk), .RST(rst), .HF_TICK(hf_tick), .LF_TICK(lf_tick), .LOW_SPEED(low_speed),
      .PRESCALE_TAP_SELECT(tap_sel), .LOWER_CTL(lo_ctl), .UPPER_CTL(up_ctl), .LOWER_EVENT_PIN(lo_pin),
      .UPPER_EVENT_PIN(up_pin), .LOWER_COUNT(lower_count), .UPPER_COUNT(upper_count), .LOWER_IRQ(lower_irq),
      .UPPER_IRQ(upper_irq), .LOWER_SRC_ERR(lower_err), .UPPER_SRC_ERR(upper_err));
   // compare helpers, one per kind of result
   task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_gap(input string what, input int exp, input int got);
      compares++;
      if (got != exp) begin
         err_total++;
         $display("wrong value %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   // ff_init kept at 0 in every counting mode
   function automatic tmc_pkg::tmc_ctl_s mk(input logic r, input logic [2:0] m, input logic [2:0] s,
      input logic [7:0] p);
      mk = '{r, m, s, 1'b0, p};
   endfunction
   // stop for one cycle, then program controls together with run; 8-bit periods kept 1..255
   // no pulse-gen mode is ever run, so its duty and period limits hold
   task automatic setup(input tmc_pkg::tmc_ctl_s lo, input tmc_pkg::tmc_ctl_s up, input logic spd,
      input logic tap);
      @(posedge clk);
      lo_ctl <= '0;
      up_ctl <= '0;
      @(posedge clk);
      lo_ctl <= lo;
      up_ctl <= up;
      low_speed <= spd;
      tap_sel <= tap;
   endtask
   // bounded wait for an irq pulse; n is the cycles waited
   task automatic wait_irq(input bit up, output int n);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while ((up ? upper_irq : lower_irq) !== 1'b1 && n < 5000);
   endtask
   task automatic t_reset();
      chk_val("counts after reset", 16'h0000, {upper_count, lower_count});
      chk_val("flags after reset", 16'h0000, {12'h000, lower_irq, upper_irq, lower_err, upper_err});
      $display("test reset done");
   endtask
   // three prescaled taps, period 3: irq every 3 ticks, one-cycle pulse, count 0 at irq
   task automatic t_timer();
      int n;
      logic [2:0] sel [3] = '{tmc_pkg::SEL_HF_8, tmc_pkg::SEL_HF_32, tmc_pkg::SEL_HF_2048};
      int div [3] = '{8, 32, 8};
      for (int i = 0; i < 3; i++) begin
         setup(mk(1'b1, tmc_pkg::MODE_TMR8, sel[i], 8'h03), '0, 1'b0, i == 2);
         wait_irq(1'b0, n);
         wait_irq(1'b0, n);
         chk_gap("timer irq gap", 3 * div[i], n);
         chk_val("count at irq", 16'h0000, {8'h00, lower_count});
         @(posedge clk);
         #1;
         chk_val("irq after one cycle", 16'h0000, {15'h0000, lower_irq});
      end
      $display("test timer done");
   endtask
   // illegal sources are refused; legal ones per mode and speed are accepted
   task automatic t_source();
      setup(mk(1'b1, tmc_pkg::MODE_TMR8, tmc_pkg::SEL_HF, 8'h03),
         mk(1'b1, tmc_pkg::MODE_PWM8, tmc_pkg::SEL_HF, 8'h80), 1'b0, 1'b0);
      repeat (20) @(posedge clk);
      #1;
      chk_val("timer on full clock", 16'h0001, {8'h00, 7'h00, lower_err});
      chk_val("refused count", 16'h0000, {8'h00, lower_count});
      chk_val("pwm on full clock", 16'h0000, {15'h0000, upper_err});
      setup(mk(1'b1, tmc_pkg::MODE_TMR8, tmc_pkg::SEL_HF_128, 8'h03),
         mk(1'b1, tmc_pkg::MODE_TMR8, tmc_pkg::SEL_HF_2048, 8'h03), 1'b1, 1'b0);
      repeat (4) @(posedge clk);
      #1;
      chk_val("low speed errs", 16'h0002, {14'h0000, lower_err, upper_err});
      // warm-up at full speed wants the low clock; only the lower select counts, the upper one is ignored
      setup(mk(1'b0, tmc_pkg::MODE_LOW16, tmc_pkg::SEL_HF, 8'h00),
         mk(1'b1, tmc_pkg::MODE_WARM16, tmc_pkg::SEL_LF, 8'h01), 1'b0, 1'b0);
      repeat (4) @(posedge clk);
      #1;
      chk_val("warm-up on high clock", 16'h0003, {14'h0000, lower_err, upper_err});
      setup(mk(1'b0, tmc_pkg::MODE_LOW16, tmc_pkg::SEL_LF, 8'h00),
         mk(1'b1, tmc_pkg::MODE_WARM16, tmc_pkg::SEL_HF, 8'h01), 1'b0, 1'b0);
      repeat (4) @(posedge clk);
      #1;
      chk_val("warm-up on low clock", 16'h0000, {14'h0000, lower_err, upper_err});
      $display("test source done");
   endtask
   // each counter counts falls of its own pin and clears on match; the lower one then resumes
   task automatic t_event();
      int n;
      setup(mk(1'b1, tmc_pkg::MODE_TMR8, tmc_pkg::SEL_PIN, 8'h04),
         mk(1'b1, tmc_pkg::MODE_TMR8, tmc_pkg::SEL_PIN, 8'h02), 1'b0, 1'b0);
      src_lo.pulses(3, 2);
      repeat (4) @(posedge clk);
      #1;
      chk_val("counts after three falls", 16'h0003, {upper_count, lower_count});
      fork
         src_lo.pulses(1, 2);
         wait_irq(1'b0, n);
      join
      chk_val("event irq", 16'h0001, {15'h0000, lower_irq});
      chk_val("event count cleared", 16'h0000, {8'h00, lower_count});
      src_lo.pulses(1, 3);
      repeat (4) @(posedge clk);
      // the irq stands one cycle, so it is judged inside the fork before the source finishes
      fork
         src_up.pulses(2, 3);
         begin
            wait_irq(1'b1, n);
            chk_val("upper irq, lower kept", 16'h0101, {7'h00, upper_irq, lower_count});
            chk_val("upper event count cleared", 16'h0000, {8'h00, upper_count});
         end
      join
      $display("test event done");
   endtask
   // 16-bit: source from lower select, upper clocked by lower overflow
   task automatic t_cascade();
      int n;
      setup(mk(1'b0, tmc_pkg::MODE_LOW16, tmc_pkg::SEL_HF_8, 8'h02),
         mk(1'b1, tmc_pkg::MODE_TMR16, tmc_pkg::SEL_HF, 8'h01), 1'b0, 1'b0);
      wait_irq(1'b1, n);
      wait_irq(1'b1, n);
      chk_gap("cascade irq gap", 258 * 8, n);
      chk_val("cascade count at irq", 16'h0000, {upper_count, lower_count});
      n = 0;
      while (lower_count !== 8'hFF && n < 3000) begin
         @(posedge clk);
         #1;
         n++;
      end
      while (lower_count === 8'hFF && n < 3000) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk_val("carry into upper", 16'h0100, {upper_count, lower_count});
      chk_val("upper select ignored", 16'h0000, {15'h0000, upper_err});
      $display("test cascade done");
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      t_reset();
      t_timer();
      t_source();
      t_event();
      t_cascade();
      stop_test();
   end
   // watchdog sized well above the expected run of about 6600 cycles
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      stop_test();
   end
endmodule
`default_nettype wire
